/* rtl/bpci_change.sv */
`default_nettype none
module bpci_change (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset
    input wire logic ce, // Clock enable
    bpci_chg_if.unit chg // Compare port
);
    logic [3:0] old_r;
    logic [3:0] old_nxt;

    assign chg.mismatch = |((chg.cur ^ old_r) & chg.inp_en);

    always_comb begin
        old_nxt = old_r;
        if (ce && chg.refresh_port) begin
            old_nxt[1:0] = chg.cur[1:0];
        end
        if (ce && chg.refresh_nb) begin
            old_nxt[3:2] = chg.cur[3:2];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            old_r <= bpci_pkg::OLD_RST;
        end else begin
            old_r <= old_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    latch_refresh_a: assert property (
        ce && chg.refresh_port |=> old_r[1:0] == $past(chg.cur[1:0]))
        else $error("compare latch not refreshed");
    exclude_out_a: assert property (
        chg.inp_en == 4'h0 |-> !chg.mismatch)
        else $error("output pin caused mismatch");
endmodule
`default_nettype wire

/* rtl/bpci_port.sv */
// The register addresses and the plain strobed port were chosen for this implementation.
`default_nettype none
// Overview of operation
// - Eight pins; direction bit one makes pin input, driver off.
// - Direction bit zero drives the output latch bit onto the pin.
// - Output latch is mapped; reading it returns latch, not pins.
// - Clearing shared active-low pull-up bit enables weak pull-ups on all input pins.
// - Pull-up forced off on any pin configured as output.
// - Pull-ups disabled after power-on reset.
// - Pins two, three analog at reset when placement strap cleared.
// - Analog-capable pins analog at reset when analog strap set.
// - Analog pin reads zero digitally; output path unaffected.
// - Only monitored pins configured as inputs join the comparison.
// - Pins two, three and neighbour zero, one compared; mismatch sets flag.
// - Change interrupt can wake the device from sleep and idle.
// - Mismatch keeps setting flag; software accesses port, waits, clears.
// - Memory-to-memory move write does not refresh the compare latch.
// - Pin returning to latched state ends mismatch without access.
// - PWM outputs share pins 0,1,4-7; pins 2,3 feed external irqs.
// - Change enable at main control bit three; flag sticky.
// - Flag sets on mismatch whatever the enable bits.
module bpci_port (
    input wire logic CLK, // Clock, 200 MHz
    input wire logic SYS_RST, // Async reset, active high
    input wire logic CE, // Clock enable
    input wire logic [2:0] ADDR, // Register index
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    input wire logic MOVE_ACCESS, // Access is mem-to-mem move
    output logic [7:0] RDATA, // Read data, cycle after RD
    input wire logic [7:0] PIN_I, // Pin levels
    output logic [7:0] PIN_O, // Pin drive value
    output logic [7:0] PIN_OE, // Pin drive enable
    output logic [7:0] PULLUP_EN, // Weak pull-up enable
    input wire logic [1:0] NB_PIN_I, // Neighbour pins 1:0
    input wire logic [1:0] NB_DIR, // Neighbour direction, 1 input
    input wire logic NB_READ, // Neighbour port read
    input wire logic LOWOSC_PLACE, // Low-osc placement strap
    input wire logic ANALOG_AT_RESET, // Analog-at-reset strap
    input wire logic PWM_EN, // PWM owns pins 0,1,4-7
    input wire logic [5:0] PWM_OUT, // PWM outputs 5:0
    output logic CHANGE_IRQ, // Flag and enable
    output logic WAKE_REQ, // Wake from sleep or idle
    output logic [1:0] EXT_IRQ // Pin 3:2 levels to ext irq
);
    logic [7:0] pin_s;
    logic [1:0] nb_s;
    logic [1:0] strap_s;
    logic [7:0] pin_dig;
    logic [7:0] pwm_map;
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic [7:0] lat_r;
    logic [7:0] lat_nxt;
    logic [7:0] an_r;
    logic [7:0] an_nxt;
    logic flag_r;
    logic flag_nxt;
    logic en_r;
    logic en_nxt;
    logic pud_r;
    logic pud_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] pin_o_nxt;
    logic [7:0] pin_oe_nxt;
    logic [7:0] pullup_nxt;
    logic irq_nxt;
    logic [1:0] ext_nxt;
    logic [7:0] strap_an;
    bpci_pkg::bpci_init_e init_r;
    bpci_pkg::bpci_init_e init_nxt;
    logic wr_pins;
    logic rd_pins;

    bpci_chg_if chg ();

    bpci_sync #(.W(8)) u_pin_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .d(PIN_I),
        .q(pin_s)
    );

    bpci_sync #(.W(4)) u_misc_sync (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .d({ANALOG_AT_RESET, LOWOSC_PLACE, NB_PIN_I}),
        .q({strap_s, nb_s})
    );

    bpci_change u_change (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .chg(chg)
    );

    assign pin_dig = pin_s & ~an_r;
    assign pwm_map = {PWM_OUT[5:2], 2'b00, PWM_OUT[1:0]};
    assign wr_pins = WR && ADDR == bpci_pkg::A_PINS;
    assign rd_pins = RD && ADDR == bpci_pkg::A_PINS;

    assign strap_an = (strap_s[1] ? bpci_pkg::ANALOG_MASK : 8'h00)
        | (strap_s[0] ? 8'h00 : bpci_pkg::PIN23_MASK);

    assign chg.cur = {nb_s, pin_dig[bpci_pkg::MON_LO +: 2]};
    assign chg.inp_en = {NB_DIR,
        dir_r[bpci_pkg::MON_LO +: 2] & ~an_r[bpci_pkg::MON_LO +: 2]};
    assign chg.refresh_port = rd_pins || (wr_pins && !MOVE_ACCESS);
    assign chg.refresh_nb = NB_READ;

    always_comb begin
        init_nxt = init_r;
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        an_nxt = an_r;
        en_nxt = en_r;
        pud_nxt = pud_r;
        flag_nxt = flag_r;
        rdata_nxt = RDATA;
        if (CE) begin
            case (init_r)
                bpci_pkg::INIT_S1: init_nxt = bpci_pkg::INIT_S2;
                bpci_pkg::INIT_S2: init_nxt = bpci_pkg::INIT_LOAD;
                bpci_pkg::INIT_LOAD: init_nxt = bpci_pkg::INIT_RUN;
                bpci_pkg::INIT_RUN: init_nxt = bpci_pkg::INIT_RUN;
                default: init_nxt = bpci_pkg::INIT_RUN;
            endcase
            if (WR) begin
                case (ADDR)
                    bpci_pkg::A_PINS: lat_nxt = WDATA;
                    bpci_pkg::A_DIR: dir_nxt = WDATA;
                    bpci_pkg::A_LAT: lat_nxt = WDATA;
                    bpci_pkg::A_MAIN: begin
                        en_nxt = WDATA[bpci_pkg::MAIN_EN_BIT];
                        flag_nxt = WDATA[bpci_pkg::MAIN_FLAG_BIT];
                    end
                    bpci_pkg::A_SECOND: begin
                        pud_nxt = WDATA[bpci_pkg::SECOND_PUD_BIT];
                    end
                    bpci_pkg::A_ANALOG: begin
                        an_nxt = WDATA & bpci_pkg::ANALOG_MASK;
                    end
                    default: ;
                endcase
            end
            // Strap load wins over an early analog write
            if (init_r == bpci_pkg::INIT_LOAD) begin
                an_nxt = strap_an;
            end
            if (chg.mismatch) begin
                flag_nxt = 1'b1;
            end
            rdata_nxt = bpci_pkg::RDATA_RST;
            if (RD) begin
                case (ADDR)
                    bpci_pkg::A_PINS: rdata_nxt = pin_dig;
                    bpci_pkg::A_DIR: rdata_nxt = dir_r;
                    bpci_pkg::A_LAT: rdata_nxt = lat_r;
                    bpci_pkg::A_MAIN: begin
                        rdata_nxt[bpci_pkg::MAIN_EN_BIT] = en_r;
                        rdata_nxt[bpci_pkg::MAIN_FLAG_BIT] = flag_r;
                    end
                    bpci_pkg::A_SECOND: begin
                        rdata_nxt[bpci_pkg::SECOND_PUD_BIT] = pud_r;
                    end
                    bpci_pkg::A_ANALOG: rdata_nxt = an_r;
                    default: rdata_nxt = bpci_pkg::RDATA_RST;
                endcase
            end
        end
    end

    always_comb begin
        pin_o_nxt = PIN_O;
        pin_oe_nxt = PIN_OE;
        pullup_nxt = PULLUP_EN;
        irq_nxt = CHANGE_IRQ;
        ext_nxt = EXT_IRQ;
        if (CE) begin
            pin_o_nxt = PWM_EN ? ((lat_r & ~bpci_pkg::PWM_MASK)
                | (pwm_map & bpci_pkg::PWM_MASK)) : lat_r;
            pin_oe_nxt = ~dir_r;
            pullup_nxt = {8{~pud_r}} & dir_r;
            irq_nxt = flag_r && en_r;
            ext_nxt = pin_dig[bpci_pkg::MON_LO +: 2];
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            init_r <= bpci_pkg::INIT_S1;
            dir_r <= bpci_pkg::DIR_RST;
            lat_r <= bpci_pkg::LAT_RST;
            an_r <= bpci_pkg::ANALOG_RST;
            en_r <= bpci_pkg::EN_RST;
            pud_r <= bpci_pkg::PUD_RST;
            flag_r <= bpci_pkg::FLAG_RST;
            RDATA <= bpci_pkg::RDATA_RST;
            PIN_O <= bpci_pkg::LAT_RST;
            PIN_OE <= ~bpci_pkg::DIR_RST;
            PULLUP_EN <= 8'h00;
            CHANGE_IRQ <= 1'b0;
            WAKE_REQ <= 1'b0;
            EXT_IRQ <= 2'b00;
        end else begin
            init_r <= init_nxt;
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            an_r <= an_nxt;
            en_r <= en_nxt;
            pud_r <= pud_nxt;
            flag_r <= flag_nxt;
            RDATA <= rdata_nxt;
            PIN_O <= pin_o_nxt;
            PIN_OE <= pin_oe_nxt;
            PULLUP_EN <= pullup_nxt;
            CHANGE_IRQ <= irq_nxt;
            WAKE_REQ <= irq_nxt;
            EXT_IRQ <= ext_nxt;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    input_hiz_a: assert property (
        CE |=> PIN_OE == ~$past(dir_r))
        else $error("drive enable does not follow direction");
    latch_drive_a: assert property (
        CE && !PWM_EN |=> PIN_O == $past(lat_r))
        else $error("pin drive is not the latch");
    latch_read_a: assert property (
        CE && RD && ADDR == bpci_pkg::A_LAT |=> RDATA == $past(lat_r))
        else $error("latch read returned wrong value");
    pullup_on_a: assert property (
        CE && !pud_r |=> PULLUP_EN == $past(dir_r))
        else $error("pull-ups not enabled on inputs");
    pullup_out_a: assert property (
        (PULLUP_EN & PIN_OE) == 8'h00)
        else $error("pull-up on driven pin");
    pullup_reset_a: assert property (
        $fell(SYS_RST) |-> PULLUP_EN == 8'h00 && pud_r)
        else $error("pull-up active after reset");
    strap_load_a: assert property (
        CE && init_r == bpci_pkg::INIT_LOAD |=> an_r == $past(strap_an))
        else $error("analog straps not loaded");
    analog_zero_a: assert property (
        CE && RD && ADDR == bpci_pkg::A_PINS
        |=> (RDATA & $past(an_r)) == 8'h00)
        else $error("analog pin read non-zero");
    flag_set_a: assert property (
        CE && chg.mismatch |=> flag_r)
        else $error("mismatch did not set flag");
    flag_hold_a: assert property (
        CE && flag_r && !(WR && ADDR == bpci_pkg::A_MAIN) |=> flag_r)
        else $error("flag dropped without clear");
    move_skip_a: assert property (
        WR && MOVE_ACCESS |-> !chg.refresh_port)
        else $error("move write refreshed compare latch");
    out_excluded_a: assert property (
        dir_r[bpci_pkg::MON_LO +: 2] == 2'h0 && NB_DIR == 2'h0
        |-> !chg.mismatch)
        else $error("output pin joined comparison");
    wake_a: assert property (
        CE |=> WAKE_REQ == ($past(flag_r) && $past(en_r)))
        else $error("wake request wrong");

    flag_cov: cover property (CE && chg.mismatch ##1 flag_r);
    clear_cov: cover property (
        rd_pins && CE ##1 flag_r ##1 (CE && WR && ADDR == bpci_pkg::A_MAIN)
        ##1 !flag_r);
    move_cov: cover property (CE && wr_pins && MOVE_ACCESS);
endmodule
`default_nettype wire

/* rtl/bpci_sync.sv */
`default_nettype none
module bpci_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] stage1_r;
    logic [W-1:0] stage1_nxt;
    logic [W-1:0] q_nxt;

    always_comb begin
        stage1_nxt = ce ? d : stage1_r;
        q_nxt = ce ? stage1_r : q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_r <= '0;
            q <= '0;
        end else begin
            stage1_r <= stage1_nxt;
            q <= q_nxt;
        end
    end
endmodule
`default_nettype wire

/* shared/bpci_chg_if.sv */
`default_nettype none
interface bpci_chg_if;
    logic [3:0] cur;
    logic [3:0] inp_en;
    logic refresh_port;
    logic refresh_nb;
    logic mismatch;
    modport top (output cur, output inp_en, output refresh_port,
                 output refresh_nb, input mismatch);
    modport unit (input cur, input inp_en, input refresh_port,
                  input refresh_nb, output mismatch);
endinterface
`default_nettype wire

/* shared/bpci_pkg.sv */
`default_nettype none
package bpci_pkg;
    localparam int DW = 8;
    localparam int AW = 3;
    localparam int NMON = 4;

    // Register offsets (word index on the plain port)
    localparam logic [2:0] A_PINS = 3'h0;
    localparam logic [2:0] A_DIR = 3'h1;
    localparam logic [2:0] A_LAT = 3'h2;
    localparam logic [2:0] A_MAIN = 3'h3;
    localparam logic [2:0] A_SECOND = 3'h4;
    localparam logic [2:0] A_ANALOG = 3'h5;

    // Field positions
    localparam int MAIN_FLAG_BIT = 0;
    localparam int MAIN_EN_BIT = 3;
    localparam int SECOND_PUD_BIT = 7;
    localparam int MON_LO = 2;

    // Reset values
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] ANALOG_RST = 8'h1F;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic FLAG_RST = 1'b0;
    localparam logic EN_RST = 1'b0;
    localparam logic PUD_RST = 1'b1;
    localparam logic [3:0] OLD_RST = 4'h0;

    // Pin groups
    localparam logic [7:0] ANALOG_MASK = 8'h1F;
    localparam logic [7:0] PIN23_MASK = 8'h0C;
    localparam logic [7:0] PWM_MASK = 8'hF3;

    typedef enum logic [1:0] {
        INIT_S1,
        INIT_S2,
        INIT_LOAD,
        INIT_RUN
    } bpci_init_e;
endpackage
`default_nettype wire

/* test/bidir_port_with_change_irq_tb.sv */
`default_nettype none
module bidir_port_with_change_irq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, mv = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, ext_v = 8'h00, ext_oe = 8'h00, pin_i;
    logic [7:0] rdata, pin_o, pin_oe, pull;
    logic [1:0] nb_pin = 2'h0, nb_dir = 2'h0, ext_irq;
    logic nb_rd = 1'b0, aar = 1'b0, lop = 1'b0, pwm_en = 1'b0, ce = 1'b1;
    logic [5:0] pwm = 6'h00;
    logic irq, wake;
    int num_errors = 0, samples_checked = 0, cyc = 0;

    always #2.5 clk = ~clk;

    bpci_port DUT (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .MOVE_ACCESS(mv),
        .RDATA(rdata), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
        .PULLUP_EN(pull), .NB_PIN_I(nb_pin), .NB_DIR(nb_dir),
        .NB_READ(nb_rd), .LOWOSC_PLACE(lop), .ANALOG_AT_RESET(aar),
        .PWM_EN(pwm_en), .PWM_OUT(pwm), .CHANGE_IRQ(irq),
        .WAKE_REQ(wake), .EXT_IRQ(ext_irq));

    bpci_pins pins (.clk(clk), .drv_o(pin_o), .drv_oe(pin_oe),
        .pull_en(pull), .ext_v(ext_v), .ext_oe(ext_oe), .lvl(pin_i));

    function automatic logic [7:0] ea(input logic a, input logic l);
        return (a ? 8'h1F : 8'h00) | (l ? 8'h00 : 8'h0C);
    endfunction

    function automatic logic [7:0] pw(input logic [7:0] t,
                                      input logic [5:0] p);
        return {p[5:2], t[3:2], p[1:0]};
    endfunction

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d,
                      input logic m = 1'b0);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        mv <= m;
        @(posedge clk);
        wr_s <= 1'b0;
        mv <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task automatic st;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic nb_pulse;
        @(posedge clk);
        nb_rd <= 1'b1;
        @(posedge clk);
        nb_rd <= 1'b0;
    endtask

    task automatic rst_dut(input logic a, input logic l);
        @(posedge clk);
        sys_rst <= 1'b1;
        aar <= a;
        lop <= l;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        logic [7:0] d, v, p;
        int seed;
        seed = $urandom(4);
        for (int k = 0; k < 4; k++) begin
            rst_dut(k[1], k[0]);
            rd(bpci_pkg::A_ANALOG, ea(k[1], k[0]));
        end
        rd(bpci_pkg::A_DIR, 8'hFF);
        rd(bpci_pkg::A_LAT, 8'h00);
        rd(bpci_pkg::A_MAIN, 8'h00);
        rd(bpci_pkg::A_SECOND, 8'h80);
        chk(pull, 8'h00);
        rd(3'h6, 8'h00);
        rd(3'h7, 8'h00);
        $display("Test reset done");

        for (int k = 0; k < 8; k++) begin
            d = 8'($urandom);
            v = 8'($urandom);
            wr(k[0] ? bpci_pkg::A_PINS : bpci_pkg::A_LAT, v);
            wr(bpci_pkg::A_DIR, d);
            rd(bpci_pkg::A_LAT, v);
            chk(pin_oe, ~d);
            chk(pin_o & ~d, v & ~d);
        end
        $display("Test direction done");

        wr(bpci_pkg::A_ANALOG, 8'h00);
        wr(bpci_pkg::A_DIR, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            v = 8'($urandom);
            @(posedge clk);
            ext_oe <= 8'hFF;
            ext_v <= v;
            st();
            rd(bpci_pkg::A_PINS, v);
            chk({6'h00, ext_irq}, {6'h00, v[3:2]});
        end
        wr(bpci_pkg::A_ANALOG, 8'h1F);
        rd(bpci_pkg::A_PINS, v & 8'hE0);
        wr(bpci_pkg::A_ANALOG, 8'h00);
        $display("Test input done");

        d = 8'($urandom);
        @(posedge clk);
        ext_oe <= 8'h00;
        wr(bpci_pkg::A_LAT, 8'h5A);
        wr(bpci_pkg::A_DIR, d);
        wr(bpci_pkg::A_SECOND, 8'h00);
        st();
        chk(pull, d);
        rd(bpci_pkg::A_PINS, d | (8'h5A & ~d));
        wr(bpci_pkg::A_SECOND, 8'h80);
        st();
        chk(pull, 8'h00);
        rd(bpci_pkg::A_SECOND, 8'h80);
        @(posedge clk);
        ce <= 1'b0;
        wr(bpci_pkg::A_LAT, 8'hA5);
        st();
        chk(pin_o, 8'h5A);
        @(posedge clk);
        ce <= 1'b1;
        rd(bpci_pkg::A_LAT, 8'h5A);
        $display("Test pull-up done");

        wr(bpci_pkg::A_DIR, 8'h00);
        p = 8'($urandom);
        @(posedge clk);
        pwm_en <= 1'b1;
        pwm <= p[5:0];
        st();
        chk(pin_o, pw(8'h5A, p[5:0]));
        @(posedge clk);
        pwm_en <= 1'b0;
        $display("Test pwm done");

        wr(bpci_pkg::A_DIR, 8'hFF);
        @(posedge clk);
        ext_oe <= 8'hFF;
        ext_v <= 8'h00;
        nb_dir <= 2'h3;
        nb_pin <= 2'h0;
        st();
        rd(bpci_pkg::A_PINS, 8'h00);
        nb_pulse();
        wr(bpci_pkg::A_MAIN, 8'h00);
        rd(bpci_pkg::A_MAIN, 8'h00);
        for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            if (j < 2)
                ext_v[j + 2] <= 1'b1;
            else
                nb_pin[j - 2] <= 1'b1;
            st();
            rd(bpci_pkg::A_MAIN, 8'h01);
            chk({7'h00, irq}, 8'h00);
            wr(bpci_pkg::A_MAIN, 8'h08);
            rd(bpci_pkg::A_MAIN, 8'h09);
            st();
            chk({6'h00, irq, wake}, 8'h03);
            @(posedge clk);
            ext_v <= 8'h00;
            nb_pin <= 2'h0;
            st();
            wr(bpci_pkg::A_MAIN, 8'h08);
            rd(bpci_pkg::A_MAIN, 8'h08);
            wr(bpci_pkg::A_MAIN, 8'h00);
        end
        @(posedge clk);
        ext_v <= 8'h04;
        st();
        wr(bpci_pkg::A_PINS, 8'h00, 1'b1);
        wr(bpci_pkg::A_MAIN, 8'h00);
        rd(bpci_pkg::A_MAIN, 8'h01);
        wr(bpci_pkg::A_PINS, 8'h00);
        wr(bpci_pkg::A_MAIN, 8'h00);
        rd(bpci_pkg::A_MAIN, 8'h00);
        @(posedge clk);
        ext_v <= 8'h00;
        nb_pin <= 2'h1;
        st();
        rd(bpci_pkg::A_PINS, 8'h00);
        nb_pulse();
        wr(bpci_pkg::A_MAIN, 8'h00);
        rd(bpci_pkg::A_MAIN, 8'h00);
        wr(bpci_pkg::A_DIR, 8'hF3);
        @(posedge clk);
        nb_dir <= 2'h0;
        nb_pin <= 2'h2;
        wr(bpci_pkg::A_LAT, 8'h0C);
        st();
        rd(bpci_pkg::A_MAIN, 8'h00);
        $display("Test change done");
        stop_test();
    end
endmodule
`default_nettype wire

/* test/bpci_pins.sv */
`default_nettype none
module bpci_pins (
    input wire logic clk, // Clock
    input wire logic [7:0] drv_o, // Device drive value
    input wire logic [7:0] drv_oe, // Device drive enable
    input wire logic [7:0] pull_en, // Weak pull-up on
    input wire logic [7:0] ext_v, // Outside drive value
    input wire logic [7:0] ext_oe, // Outside drive enable
    output logic [7:0] lvl // Resolved pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] flt = 8'h00;
    // Undriven pins wander
    always @(posedge clk) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drv_oe[i])
                lvl[i] = drv_o[i];
            else if (ext_oe[i])
                lvl[i] = ext_v[i];
            else if (pull_en[i])
                lvl[i] = 1'b1;
            else
                lvl[i] = flt[i];
        end
    end
endmodule
`default_nettype wire
